// *** design/math_post_consts.vh ***
// Register map, field positions and reset values of the math post-processor
`ifndef MATH_POST_CONSTS_VH
`define MATH_POST_CONSTS_VH

// ==========================================================================
// Register offsets
`define REG_CTRL         4'h0
`define REG_TARGET       4'h1
`define REG_NULL_OFS     4'h2
`define REG_UPPER        4'h3
`define REG_LOWER        4'h4
`define REG_SCALE        4'h5
`define REG_OFFSET       4'h6
`define REG_RESULT       4'h7
`define REG_MIN          4'h8
`define REG_MAX          4'h9
`define REG_MEAN         4'ha
`define REG_COUNT        4'hb
`define REG_STATUS       4'hc
`define REG_IRQ_EN       4'hd
`define REG_IRQ_CLR      4'he

// ==========================================================================
// Control fields
`define CTRL_FUNC_LSB    0
`define CTRL_FUNC_MSB    2
`define CTRL_ENABLE_BIT  3
`define CTRL_CAPTURE_BIT 4
`define CTRL_SOFTRST_BIT 5
`define CTRL_NFUNC_LSB   8
`define CTRL_NFUNC_MSB   11

// ==========================================================================
// Math operation codes
`define OP_PERCENT       3'h0
`define OP_AVERAGE       3'h1
`define OP_NULL          3'h2
`define OP_LIMIT         3'h3
`define OP_LINEAR        3'h4

// ==========================================================================
// Status bits
`define ST_RESULT        0
`define ST_OVER          1
`define ST_UNDER         2
`define ST_DIVZERO       3
`define ST_BITS          4

// ==========================================================================
// Reset values and constants
`define PERCENT_SCALE    32'h00000064
`define ZERO_WORD        32'h00000000
`endif

// *** design/reading_math_postprocessor.v ***
// Math post-processing stage applied to each finished measurement reading
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "math_post_consts.vh"

module reading_math_postprocessor #(
    parameter W         = 32,
    parameter FW        = 4,
    parameter CNT_W     = 32,
    parameter [FW-1:0] FUNC_DIODE = 4'h6,
    parameter [FW-1:0] FUNC_CONT  = 4'h7
) (
    input  wire          mclk_in,
    input  wire          sys_rst_in,
    // Reading from measurement engine
    input  wire          rd_valid_in,
    input  wire [W-1:0]  rd_data_in,
    input  wire [FW-1:0] meas_func_in,
    // Register port
    input  wire [3:0]    reg_addr_in,
    input  wire [W-1:0]  reg_wdata_in,
    input  wire          reg_wr_in,
    input  wire          reg_rd_in,
    output reg  [W-1:0]  reg_rdata_out,
    // Results
    output reg           res_valid_out,
    output reg  [W-1:0]  res_data_out,
    output reg           over_upper_flag_out,
    output reg           under_lower_flag_out,
    output reg           alert_out,
    output wire          math_active_out,
    output wire          irq_out
);

    // ======================================================================
    // Control and parameter storage
    reg [2:0]    op_reg;
    reg          enable_reg;
    reg          capture_reg;
    reg [FW-1:0] null_func_reg;
    reg [FW-1:0] func_prev_reg;
    reg [W-1:0]  target_reg;
    reg [W-1:0]  null_ofs_reg;
    reg [W-1:0]  upper_reg;
    reg [W-1:0]  lower_reg;
    reg [W-1:0]  scale_reg;
    reg [W-1:0]  offset_reg;
    reg [W-1:0]  min_reg;
    reg [W-1:0]  max_reg;
    reg [W-1:0]  mean_reg;
    reg [CNT_W-1:0] count_reg;
    reg signed [W+CNT_W-1:0] sum_reg;
    wire [`ST_BITS-1:0] status_bits;
    reg [`ST_BITS-1:0] irq_en_reg;
    reg [`ST_BITS-1:0] event_set;

    wire ctrl_wr = reg_wr_in && (reg_addr_in == `REG_CTRL);
    wire new_en  = reg_wdata_in[`CTRL_ENABLE_BIT];
    wire soft_rst = ctrl_wr && reg_wdata_in[`CTRL_SOFTRST_BIT];
    wire clear_all = sys_rst_in || soft_rst;
    wire ofs_wr   = reg_wr_in && (reg_addr_in == `REG_NULL_OFS);
    wire clr_wr   = reg_wr_in && (reg_addr_in == `REG_IRQ_CLR);
    wire func_change = (meas_func_in != func_prev_reg);
    // Averaging restart whenever enable goes from off to on
    wire avg_restart = ctrl_wr && new_en && !enable_reg;
    wire math_blocked = (meas_func_in == FUNC_DIODE) ||
                        (meas_func_in == FUNC_CONT);
    wire apply = enable_reg && !math_blocked;

    assign math_active_out = enable_reg;
    assign irq_out = |(status_bits & irq_en_reg);

    // ======================================================================
    // Arithmetic
    wire signed [W-1:0] x   = rd_data_in;
    wire signed [W-1:0] tgt = target_reg;
    wire signed [2*W-1:0] pct_prod = x * $signed(`PERCENT_SCALE);
    wire signed [2*W-1:0] lin_prod = x * $signed(scale_reg);
    wire div_zero = (target_reg == `ZERO_WORD);
    // Divide is combinational; costly but keeps one-cycle latency
    wire signed [2*W-1:0] pct_q = div_zero ? {2*W{1'b0}} :
                                  pct_prod / tgt;
    wire signed [W+CNT_W-1:0] sum_next = sum_reg + x;
    wire [CNT_W-1:0] cnt_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    wire signed [W+CNT_W-1:0] mean_q =
        sum_next / $signed({1'b0, cnt_next});
    wire null_here = (meas_func_in == null_func_reg);
    wire is_over  = x > $signed(upper_reg);
    wire is_under = x < $signed(lower_reg);

    reg [W-1:0] result;
    always @*
    begin
        result = rd_data_in;
        case (op_reg)
            `OP_PERCENT: result = pct_q[W-1:0];
            `OP_AVERAGE: result = mean_q[W-1:0];
            `OP_NULL:
                if (null_here && !capture_reg)
                    result = rd_data_in - null_ofs_reg;
            `OP_LINEAR:
                result = lin_prod[W-1:0] + offset_reg;
            default: result = rd_data_in;
        endcase
        if (!apply)
            result = rd_data_in;
    end

    always @*
    begin
        event_set = {`ST_BITS{1'b0}};
        event_set[`ST_RESULT] = rd_valid_in;
        if (rd_valid_in && apply && op_reg == `OP_LIMIT)
        begin
            event_set[`ST_OVER]  = is_over;
            event_set[`ST_UNDER] = is_under;
        end
        event_set[`ST_DIVZERO] = rd_valid_in && apply &&
                                 op_reg == `OP_PERCENT && div_zero;
    end

    // ======================================================================
    // Sequential qualifiers
    wire take_ofs = rd_valid_in && apply && (op_reg == `OP_NULL) &&
                    capture_reg && null_here;
    wire avg_take = rd_valid_in && apply && (op_reg == `OP_AVERAGE);
    wire lim_take = apply && (op_reg == `OP_LIMIT);
    wire first_rd = (count_reg == {CNT_W{1'b0}});

    // ======================================================================
    // Control: operation, enable, null function code
    always @(posedge mclk_in)
    begin
        // Tracks the live code in reset too, so no false change after it
        func_prev_reg <= meas_func_in;
        if (clear_all)
        begin
            op_reg        <= `OP_PERCENT;
            enable_reg    <= 1'b0;
            null_func_reg <= {FW{1'b0}};
        end
        else
        begin
            if (ctrl_wr)
            begin
                op_reg        <= reg_wdata_in[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
                null_func_reg <=
                    reg_wdata_in[`CTRL_NFUNC_MSB:`CTRL_NFUNC_LSB];
            end
            if (func_change)
                enable_reg <= 1'b0;
            else if (ctrl_wr)
                enable_reg <= new_en;
        end
    end

    // ======================================================================
    // Null offset: captured reading or explicit value
    always @(posedge mclk_in)
    begin
        if (clear_all)
        begin
            capture_reg  <= 1'b0;
            null_ofs_reg <= `ZERO_WORD;
        end
        else
        begin
            // A fresh capture request waits for the reading after it
            if (ctrl_wr && reg_wdata_in[`CTRL_CAPTURE_BIT])
                capture_reg <= 1'b1;
            else if (ofs_wr || take_ofs)
                capture_reg <= 1'b0;
            if (take_ofs)
                null_ofs_reg <= rd_data_in;
            else if (ofs_wr)
                null_ofs_reg <= reg_wdata_in;
        end
    end

    // ======================================================================
    // Parameter registers
    always @(posedge mclk_in)
    begin
        if (clear_all)
        begin
            target_reg <= `ZERO_WORD;
            upper_reg  <= `ZERO_WORD;
            lower_reg  <= `ZERO_WORD;
            scale_reg  <= `ZERO_WORD;
            offset_reg <= `ZERO_WORD;
            irq_en_reg <= {`ST_BITS{1'b0}};
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `REG_TARGET: target_reg <= reg_wdata_in;
                `REG_UPPER:  upper_reg  <= reg_wdata_in;
                `REG_LOWER:  lower_reg  <= reg_wdata_in;
                `REG_SCALE:  scale_reg  <= reg_wdata_in;
                `REG_OFFSET: offset_reg <= reg_wdata_in;
                `REG_IRQ_EN: irq_en_reg <= reg_wdata_in[`ST_BITS-1:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Averaging statistics
    always @(posedge mclk_in)
    begin
        if (clear_all || avg_restart)
        begin
            count_reg <= {CNT_W{1'b0}};
            sum_reg   <= {(W+CNT_W){1'b0}};
            min_reg   <= `ZERO_WORD;
            max_reg   <= `ZERO_WORD;
            mean_reg  <= `ZERO_WORD;
        end
        else if (avg_take)
        begin
            count_reg <= cnt_next;
            sum_reg   <= sum_next;
            mean_reg  <= mean_q[W-1:0];
            // First reading seeds both extremes, zero is not a reading
            if (first_rd || x < $signed(min_reg))
                min_reg <= rd_data_in;
            if (first_rd || x > $signed(max_reg))
                max_reg <= rd_data_in;
        end
    end

    // ======================================================================
    // Result word and its strobe
    always @(posedge mclk_in)
    begin
        // Soft reset leaves this path alone so no reading is lost
        if (sys_rst_in)
        begin
            res_valid_out <= 1'b0;
            res_data_out  <= `ZERO_WORD;
        end
        else
        begin
            res_valid_out <= rd_valid_in;
            if (rd_valid_in)
                res_data_out <= result;
        end
    end

    // ======================================================================
    // Limit flags, updated on every reading
    always @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            over_upper_flag_out  <= 1'b0;
            under_lower_flag_out <= 1'b0;
            alert_out            <= 1'b0;
        end
        else if (rd_valid_in)
        begin
            // Readings outside limit mode drop the flags
            over_upper_flag_out  <= lim_take && is_over;
            under_lower_flag_out <= lim_take && is_under;
            alert_out            <= lim_take &&
                                    (is_over || is_under);
        end
    end

    // ======================================================================
    // Sticky status bits
    genvar sb;
    generate
        for (sb = 0; sb < `ST_BITS; sb = sb + 1)
        begin : g_status
            reg sticky_reg;
            // An event beats a clear or soft reset in the same cycle
            always @(posedge mclk_in)
            begin
                if (sys_rst_in)
                    sticky_reg <= 1'b0;
                else if (event_set[sb])
                    sticky_reg <= 1'b1;
                else if (soft_rst || (clr_wr && reg_wdata_in[sb]))
                    sticky_reg <= 1'b0;
            end
            assign status_bits[sb] = sticky_reg;
        end
    endgenerate

    // ======================================================================
    // Register read, data valid the cycle after the strobe
    always @(posedge mclk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= `ZERO_WORD;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `REG_CTRL: reg_rdata_out <=
                    {{(W-12){1'b0}}, null_func_reg, 3'h0, capture_reg,
                     enable_reg, op_reg};
                `REG_TARGET:   reg_rdata_out <= target_reg;
                `REG_NULL_OFS: reg_rdata_out <= null_ofs_reg;
                `REG_UPPER:    reg_rdata_out <= upper_reg;
                `REG_LOWER:    reg_rdata_out <= lower_reg;
                `REG_SCALE:    reg_rdata_out <= scale_reg;
                `REG_OFFSET:   reg_rdata_out <= offset_reg;
                `REG_RESULT:   reg_rdata_out <= res_data_out;
                `REG_MIN:      reg_rdata_out <= min_reg;
                `REG_MAX:      reg_rdata_out <= max_reg;
                `REG_MEAN:     reg_rdata_out <= mean_reg;
                `REG_COUNT:    reg_rdata_out <= count_reg[W-1:0];
                `REG_STATUS:   reg_rdata_out <=
                    {{(W-`ST_BITS){1'b0}}, status_bits};
                `REG_IRQ_EN:   reg_rdata_out <=
                    {{(W-`ST_BITS){1'b0}}, irq_en_reg};
                default:       reg_rdata_out <= `ZERO_WORD;
            endcase
        end
        else
            reg_rdata_out <= `ZERO_WORD;
    end

endmodule
`default_nettype wire

// *** verification/meas_engine.sv ***
// Behavioural measurement engine feeding readings to the math stage
`timescale 1ns/1ps
`default_nettype none
module meas_engine (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [31:0] val_in,
    input  wire logic [3:0]  func_in,
    output var  logic        rd_valid_out,
    output var  logic [31:0] rd_data_out,
    output var  logic [3:0]  meas_func_out
);
    // ====
    // Reading launch
    initial
    begin
        rd_valid_out = 1'b0;
        rd_data_out = 32'h0;
        meas_func_out = 4'h0;
    end
    // Idle data toggles so a stale word never looks like a reading
    always @(posedge clk_in)
    begin
        rd_valid_out <= go_in;
        rd_data_out <= go_in ? val_in : ~rd_data_out;
        meas_func_out <= func_in;
    end
endmodule
`default_nettype wire

// *** verification/math_post_sva.sv ***
// Port assertions for the math post-processor
`timescale 1ns/1ps
`default_nettype none
`include "math_post_consts.vh"
module math_post_sva #(
    parameter W  = 32,
    parameter FW = 4
) (
    input wire logic          mclk_in,
    input wire logic          sys_rst_in,
    input wire logic          rd_valid_in,
    input wire logic [FW-1:0] meas_func_in,
    input wire logic [3:0]    reg_addr_in,
    input wire logic [W-1:0]  reg_wdata_in,
    input wire logic          reg_wr_in,
    input wire logic          reg_rd_in,
    input wire logic [W-1:0]  reg_rdata_out,
    input wire logic          res_valid_out,
    input wire logic          over_upper_flag_out,
    input wire logic          under_lower_flag_out,
    input wire logic          alert_out,
    input wire logic          math_active_out,
    input wire logic          irq_out
);
    // ====
    // Checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    wire logic ctl_wr = reg_wr_in && reg_addr_in == `REG_CTRL;
    property p_res_lat;
        rd_valid_in |=> res_valid_out;
    endproperty
    a_res_lat: assert property (p_res_lat) else $error("no result");
    property p_res_none;
        !rd_valid_in |=> !res_valid_out;
    endproperty
    a_res_none: assert property (p_res_none) else $error("stray");
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata");
    property p_alert;
        alert_out == (over_upper_flag_out || under_lower_flag_out);
    endproperty
    a_alert: assert property (p_alert) else $error("alert");
    property p_func_off;
        $changed(meas_func_in) |=> ##[0:1] !math_active_out;
    endproperty
    a_func_off: assert property (p_func_off) else $error("func");
    property p_en_on;
        ctl_wr && reg_wdata_in[3] && !reg_wdata_in[5]
            && $stable(meas_func_in) |=> math_active_out;
    endproperty
    a_en_on: assert property (p_en_on) else $error("enable");
    property p_en_off;
        ctl_wr && !reg_wdata_in[3] |=> !math_active_out;
    endproperty
    a_en_off: assert property (p_en_off) else $error("off");
    property p_irq_mask;
        reg_wr_in && reg_addr_in == `REG_IRQ_EN && reg_wdata_in == '0
            |=> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq");
endmodule
bind reading_math_postprocessor math_post_sva #(.W(W), .FW(FW)) u_sva (
    .mclk_in, .sys_rst_in, .rd_valid_in, .meas_func_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .res_valid_out,
    .over_upper_flag_out, .under_lower_flag_out, .alert_out,
    .math_active_out, .irq_out
);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the math post-processor
`timescale 1ns/1ps
`default_nettype none
`include "math_post_consts.vh"
module testbench;
    typedef struct {
        logic [3:0]  a1;
        logic [31:0] v1;
        logic [3:0]  a2;
        logic [31:0] v2;
        logic [31:0] c;
        logic [31:0] x;
        logic [31:0] y;
        logic [1:0]  fl;
    } row_t;
    logic mclk_in, sys_rst_in, go, reg_wr_in, reg_rd_in;
    logic [31:0] val, reg_wdata_in;
    logic [3:0]  func, reg_addr_in;
    wire logic rd_valid_in, res_valid_out, math_active_out, irq_out;
    wire logic over_upper_flag_out, under_lower_flag_out, alert_out;
    wire logic [31:0] rd_data_in, reg_rdata_out, res_data_out;
    wire logic [3:0]  meas_func_in;
    wire logic [31:0] fl_w = {29'h0, alert_out, over_upper_flag_out,
                              under_lower_flag_out};
    wire logic [31:0] irq_w = {31'h0, irq_out};
    wire logic [31:0] act_w = {31'h0, math_active_out};
    int   num_errors = 0;
    int   n_checks = 0;
    row_t rows [6];
    meas_engine u_src (.clk_in(mclk_in), .go_in(go), .val_in(val),
        .func_in(func), .rd_valid_out(rd_valid_in),
        .rd_data_out(rd_data_in), .meas_func_out(meas_func_in));
    reading_math_postprocessor u_dut (.mclk_in, .sys_rst_in, .rd_valid_in,
        .rd_data_in, .meas_func_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .res_valid_out, .res_data_out,
        .over_upper_flag_out, .under_lower_flag_out, .alert_out,
        .math_active_out, .irq_out);
    // ====
    // Tasks
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    // Returns one step after the edge so the write has landed
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("read", e, reg_rdata_out);
    endtask
    task automatic send(input logic [31:0] x);
        @(posedge mclk_in);
        go <= 1'b1;
        val <= x;
        @(posedge mclk_in);
        go <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk("res_valid", 32'h1, {31'h0, res_valid_out});
    endtask
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // Clock, watchdog, sequence
    initial
    begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial
    begin
        #20000;
        num_errors++;
        finish_test();
    end
    initial
    begin
        {sys_rst_in, go, val, func} = {1'b1, 1'b0, 32'h0, 4'h1};
        {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
        rows[0] = '{`REG_TARGET, 32'hc8, `REG_TARGET, 32'hc8, 32'h8,
                    32'h32, 32'h19, 2'b00};
        rows[1] = '{`REG_TARGET, 32'h0, `REG_TARGET, 32'h0, 32'h8,
                    32'h32, 32'h0, 2'b00};
        rows[2] = '{`REG_NULL_OFS, 32'h7, `REG_NULL_OFS, 32'h7, 32'h10a,
                    32'h14, 32'hd, 2'b00};
        rows[3] = '{`REG_SCALE, 32'h3, `REG_OFFSET, 32'h5, 32'hc,
                    32'h4, 32'h11, 2'b00};
        rows[4] = '{`REG_UPPER, 32'ha, `REG_LOWER, 32'h2, 32'hb,
                    32'hb, 32'hb, 2'b10};
        rows[5] = '{`REG_UPPER, 32'ha, `REG_LOWER, 32'h2, 32'hb,
                    32'h1, 32'h1, 2'b01};
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        for (int a = 1; a < 7; a++) rdc(4'(a), 32'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a1, rows[i].v1);
            wr(rows[i].a2, rows[i].v2);
            wr(`REG_CTRL, rows[i].c);
            send(rows[i].x);
            chk("result", rows[i].y, res_data_out);
            chk("flags", {29'h0, |rows[i].fl, rows[i].fl}, fl_w);
        end
        rdc(`REG_STATUS, 32'hf);
        rdc(`REG_RESULT, 32'h1);
        wr(`REG_CTRL, 32'h20a);
        send(32'h14);
        chk("other func", 32'h14, res_data_out);
        @(posedge mclk_in);
        func <= 4'h6;
        repeat (3) @(posedge mclk_in);
        chk("active", 32'h0, act_w);
        wr(`REG_CTRL, 32'hc);
        chk("active", 32'h1, act_w);
        send(32'h4);
        chk("diode", 32'h4, res_data_out);
        @(posedge mclk_in);
        func <= 4'h1;
        repeat (3) @(posedge mclk_in);
        wr(`REG_CTRL, 32'h11a);
        send(32'h9);
        send(32'hc);
        chk("capture", 32'h3, res_data_out);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_CTRL, 32'h9);
        // Back-to-back readings, no gap between strobes
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk_in);
            go <= 1'b1;
            val <= (i == 0) ? 32'h6 : (i == 1) ? 32'ha : 32'h2;
        end
        @(posedge mclk_in);
        go <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rdc(`REG_MIN, 32'h2);
        rdc(`REG_MAX, 32'ha);
        rdc(`REG_MEAN, 32'h6);
        rdc(`REG_COUNT, 32'h3);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_CTRL, 32'h9);
        rdc(`REG_COUNT, 32'h0);
        rdc(`REG_MAX, 32'h0);
        wr(`REG_IRQ_EN, 32'h1);
        chk("irq", 32'h1, irq_w);
        wr(`REG_IRQ_EN, 32'h0);
        chk("irq", 32'h0, irq_w);
        wr(`REG_IRQ_EN, 32'h1);
        wr(`REG_IRQ_CLR, 32'h1);
        chk("irq", 32'h0, irq_w);
        send(32'h1);
        chk("irq", 32'h1, irq_w);
        wr(`REG_TARGET, 32'h9);
        wr(`REG_CTRL, 32'h20);
        for (int a = 1; a < 7; a++) rdc(4'(a), 32'h0);
        rdc(`REG_COUNT, 32'h0);
        rdc(4'hf, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
